// *** src/sfr_top.sv ***
// Special-function register bank: chip identity, reset cause, protect mode.
// Assumes a single AHB-Lite master on hclk; this slave decodes via hsel.
`timescale 1ns/10ps
module sfr_top #(
  parameter logic [4:0] CHIP_VERSION = 5'h00,
  parameter logic [3:0] PROGRAM_MEMORY_SIZE = 4'h0,
  parameter logic [3:0] NONVOLATILE_DATA_SIZE = 4'h0,
  parameter logic [3:0] VOLATILE_DATA_SIZE = 4'h4,
  // Arbitrary neutral family code, two BCD digits
  parameter logic [7:0] FAMILY_CODE = 8'h12,
  parameter logic [2:0] PROGRAM_MEMORY_TYPE = 3'h1,
  parameter logic IDENTITY_EXTENDED = 1'b0,
  parameter int ADDR_W = 32
) (
  input wire logic hclk, // Bus clock, 50 MHz
  input wire logic hresetn, // System reset, async, active low
  input wire logic poresetn, // Power-on reset, async, active low
  input wire logic hsel, // Slave select
  input wire logic [ADDR_W-1:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Slave ready
  output logic hresp, // Response, always OKAY
  output logic [31:0] hrdata, // Read data
  input wire logic wdog_reset_req, // Watchdog overflow reset request
  output logic sys_reset_req, // Reset request toward reset controller
  output logic interrupt_protect_enable // Interrupt controller protect mode
);

  sfr_cause_if cause_bus ();

  sfr_reset_cause u_cause (
    .hclk (hclk),
    .hresetn (hresetn),
    .poresetn (poresetn),
    .wdog_reset_req (wdog_reset_req),
    .cause_bus (cause_bus)
  );

  // Reserved codes collapse to "none" so software never sees them
  function automatic logic [3:0] legal_psize(input logic [3:0] code);
    logic [3:0] res;
    res = sfr_pkg::PSIZE_NONE;
    case (code)
      sfr_pkg::PSIZE_32K: res = code;
      sfr_pkg::PSIZE_64K: res = code;
      sfr_pkg::PSIZE_128K: res = code;
      sfr_pkg::PSIZE_256K: res = code;
      default: res = sfr_pkg::PSIZE_NONE;
    endcase
    return res;
  endfunction

  // Only one-hot sizes are legal
  function automatic logic [3:0] legal_vdsize(input logic [3:0] code);
    logic [3:0] res;
    res = sfr_pkg::VDSIZE_NONE;
    case (code)
      sfr_pkg::VDSIZE_1K: res = code;
      sfr_pkg::VDSIZE_2K: res = code;
      sfr_pkg::VDSIZE_4K: res = code;
      sfr_pkg::VDSIZE_8K: res = code;
      default: res = sfr_pkg::VDSIZE_NONE;
    endcase
    return res;
  endfunction

  // Only "none" is defined, so every other code collapses to it
  function automatic logic [3:0] legal_nvdsize(input logic [3:0] code);
    logic [3:0] res;
    res = sfr_pkg::NVDSIZE_NONE;
    case (code)
      sfr_pkg::NVDSIZE_NONE: res = code;
      default: res = sfr_pkg::NVDSIZE_NONE;
    endcase
    return res;
  endfunction

  // Each nibble must be a decimal digit; a bad digit reads as zero
  function automatic logic [7:0] legal_family(input logic [7:0] code);
    logic [7:0] res;
    res = code;
    for (int i = 0; i < 2; i++) begin
      if (code[4*i +: 4] > 4'h9) begin
        res[4*i +: 4] = 4'h0;
      end
    end
    return res;
  endfunction

  // Reserved types fall back to ROM, the plainest defined kind
  function automatic logic [2:0] legal_ptype(input logic [2:0] code);
    logic [2:0] res;
    res = sfr_pkg::PTYPE_ROM;
    case (code)
      sfr_pkg::PTYPE_ROM: res = code;
      sfr_pkg::PTYPE_FLASH_PARALLEL: res = code;
      sfr_pkg::PTYPE_FLASH_SERIAL: res = code;
      default: res = sfr_pkg::PTYPE_ROM;
    endcase
    return res;
  endfunction

  // Hardwired identity word
  logic [31:0] identity_word;

  always_comb begin
    identity_word = sfr_pkg::READ_ZERO;
    identity_word[sfr_pkg::VERSION_LSB +: 5] = CHIP_VERSION;
    identity_word[sfr_pkg::FIXED_LSB +: 3] = sfr_pkg::ID_FIXED_BITS;
    identity_word[sfr_pkg::PSIZE_LSB +: 4] =
      legal_psize(PROGRAM_MEMORY_SIZE);
    identity_word[sfr_pkg::NVDSIZE_LSB +: 4] =
      legal_nvdsize(NONVOLATILE_DATA_SIZE);
    identity_word[sfr_pkg::VDSIZE_LSB +: 4] =
      legal_vdsize(VOLATILE_DATA_SIZE);
    identity_word[sfr_pkg::FAMILY_LSB +: 8] = legal_family(FAMILY_CODE);
    identity_word[sfr_pkg::PTYPE_LSB +: 3] =
      legal_ptype(PROGRAM_MEMORY_TYPE);
    identity_word[sfr_pkg::EXT_BIT] = IDENTITY_EXTENDED;
  end

  // Bus state
  sfr_pkg::sfr_state_t state_ff;
  sfr_pkg::sfr_state_t nxt_state;
  logic [7:0] addr_ff;
  logic hit_ff;
  logic hreadyout_ff;
  logic [31:0] hrdata_ff;
  logic protect_ff;

  logic accept;
  logic accept_write;
  logic accept_read;
  logic in_bank;
  logic [31:0] read_mux;
  logic key_ok;
  logic protect_write;

  // Address phase is taken only when the bus is ready
  assign accept = hsel & hready & (htrans == sfr_pkg::HTRANS_NONSEQ);
  assign accept_write = accept & hwrite;
  assign accept_read = accept & ~hwrite;

  // Upper address bits must all be zero for a hit; the low byte selects the register
  assign in_bank = ~|haddr[ADDR_W-1:8];

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      sfr_pkg::ST_IDLE,
      sfr_pkg::ST_WRITE,
      sfr_pkg::ST_READ_DONE: begin
        if (accept_write) begin
          nxt_state = sfr_pkg::ST_WRITE;
        end else if (accept_read) begin
          nxt_state = sfr_pkg::ST_READ_WAIT;
        end else begin
          nxt_state = sfr_pkg::ST_IDLE;
        end
      end
      sfr_pkg::ST_READ_WAIT: begin
        nxt_state = sfr_pkg::ST_READ_DONE;
      end
      default: begin
        nxt_state = sfr_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= sfr_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Latch the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_ff <= 8'h00;
      hit_ff <= 1'b0;
    end else if (accept) begin
      addr_ff <= haddr[7:0];
      hit_ff <= in_bank & (hsize == 3'h2) & (haddr[1:0] == 2'h0);
    end
  end

  // Reads take one wait state, so read data always follows any write
  // that finished just before, at the price of one cycle per read.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_ff <= 1'b1;
    end else if (accept_read && state_ff != sfr_pkg::ST_READ_WAIT) begin
      hreadyout_ff <= 1'b0;
    end else begin
      hreadyout_ff <= 1'b1;
    end
  end

  // Read side as a table of eight words, one per word index of the window.
  // Unmapped and reserved entries stay zero, so a miss inside the window needs no extra path.
  localparam int SLOT_N = 8;
  logic [31:0] slot_word [SLOT_N];
  logic [2:0] slot_idx;
  logic slot_hit;
  logic [31:0] cause_word;
  logic [31:0] protect_word;

  assign slot_idx = addr_ff[4:2];
  // Offsets above the window fall outside the table and read zero
  assign slot_hit = hit_ff & ~|addr_ff[7:5];

  always_comb begin
    cause_word = sfr_pkg::READ_ZERO;
    cause_word[7:0] = cause_bus.cause;
  end

  always_comb begin
    protect_word = sfr_pkg::READ_ZERO;
    // Key half stays zero on read
    protect_word[sfr_pkg::PROTECT_BIT] = protect_ff;
  end

  for (genvar g = 0; g < SLOT_N; g++) begin : g_slot
    localparam logic [7:0] SLOT_OFS = 8'(4 * g);
    if (SLOT_OFS == sfr_pkg::OFS_CHIP_IDENTITY) begin : g_id
      assign slot_word[g] = identity_word;
    end else if (SLOT_OFS == sfr_pkg::OFS_RESET_CAUSE) begin : g_cause
      assign slot_word[g] = cause_word;
    end else if (SLOT_OFS == sfr_pkg::OFS_PROTECT_MODE_CONTROL) begin : g_protect
      assign slot_word[g] = protect_word;
    end else begin : g_zero
      // Extension word and reserved words carry nothing
      assign slot_word[g] = sfr_pkg::READ_ZERO;
    end
  end

  assign read_mux = slot_hit ? slot_word[slot_idx] : sfr_pkg::READ_ZERO;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= sfr_pkg::READ_ZERO;
    end else if (state_ff == sfr_pkg::ST_READ_WAIT) begin
      hrdata_ff <= read_mux;
    end else if (state_ff == sfr_pkg::ST_READ_DONE) begin
      hrdata_ff <= sfr_pkg::READ_ZERO;
    end
  end

  // Protect mode write: key must match or the whole write is dropped
  assign key_ok =
    (hwdata[sfr_pkg::KEY_LSB +: 16] == sfr_pkg::PROTECT_WRITE_KEY);
  assign protect_write = (state_ff == sfr_pkg::ST_WRITE) & hit_ff &
    (addr_ff == sfr_pkg::OFS_PROTECT_MODE_CONTROL) & key_ok;

  // Writes elsewhere change nothing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      protect_ff <= sfr_pkg::PROTECT_RESET;
    end else if (protect_write) begin
      protect_ff <= hwdata[sfr_pkg::PROTECT_BIT];
    end
  end

  assign hreadyout = hreadyout_ff;
  assign hresp = sfr_pkg::HRESP_OKAY;
  assign hrdata = hrdata_ff;
  assign interrupt_protect_enable = protect_ff;
  assign sys_reset_req = cause_bus.sys_reset_req;

endmodule

// *** inc/sfr_pkg.sv ***
// Constants for the special-function register bank: map, fields, codes.
// Assumes a 32-bit AHB-Lite bus with word-aligned registers.
package sfr_pkg;

  // Register byte offsets inside the bank
  localparam logic [7:0] OFS_CHIP_IDENTITY = 8'h00;
  localparam logic [7:0] OFS_CHIP_IDENTITY_EXTENSION = 8'h04;
  localparam logic [7:0] OFS_RESET_CAUSE = 8'h08;
  localparam logic [7:0] OFS_RESERVED_0 = 8'h0c;
  localparam logic [7:0] OFS_RESERVED_1 = 8'h10;
  localparam logic [7:0] OFS_RESERVED_2 = 8'h14;
  localparam logic [7:0] OFS_PROTECT_MODE_CONTROL = 8'h18;
  localparam logic [31:0] BANK_BASE = 32'hfff00000;

  // Identity word field positions (lsb)
  localparam int VERSION_LSB = 0;
  localparam int FIXED_LSB = 5;
  localparam int PSIZE_LSB = 8;
  localparam int NVDSIZE_LSB = 12;
  localparam int VDSIZE_LSB = 16;
  localparam int FAMILY_LSB = 20;
  localparam int PTYPE_LSB = 28;
  localparam int EXT_BIT = 31;
  localparam logic [2:0] ID_FIXED_BITS = 3'h2;

  // Program memory size codes
  localparam logic [3:0] PSIZE_NONE = 4'h0;
  localparam logic [3:0] PSIZE_32K = 4'h3;
  localparam logic [3:0] PSIZE_64K = 4'h5;
  localparam logic [3:0] PSIZE_128K = 4'h7;
  localparam logic [3:0] PSIZE_256K = 4'h9;

  // Nonvolatile data memory: only "none" is defined
  localparam logic [3:0] NVDSIZE_NONE = 4'h0;

  // Volatile data memory size codes, one-hot
  localparam logic [3:0] VDSIZE_NONE = 4'h0;
  localparam logic [3:0] VDSIZE_1K = 4'h1;
  localparam logic [3:0] VDSIZE_2K = 4'h2;
  localparam logic [3:0] VDSIZE_4K = 4'h4;
  localparam logic [3:0] VDSIZE_8K = 4'h8;

  // Program memory type codes
  localparam logic [2:0] PTYPE_ROM = 3'h1;
  localparam logic [2:0] PTYPE_FLASH_PARALLEL = 3'h2;
  localparam logic [2:0] PTYPE_FLASH_SERIAL = 3'h3;

  // Reset cause codes
  localparam logic [7:0] CAUSE_EXTERNAL_PIN = 8'h6c;
  localparam logic [7:0] CAUSE_WATCHDOG = 8'h53;

  // Protect mode register
  localparam int PROTECT_BIT = 5;
  localparam int KEY_LSB = 16;
  localparam logic [15:0] PROTECT_WRITE_KEY = 16'h27a8;
  localparam logic PROTECT_RESET = 1'b0;

  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic [31:0] READ_ZERO = 32'h00000000;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WRITE,
    ST_READ_WAIT,
    ST_READ_DONE
  } sfr_state_t;

endpackage

// *** inc/sfr_cause_if.sv ***
// Carries the captured reset cause from the cause tracker to the bank.
// Both ends sit on hclk; no crossing is involved.
`timescale 1ns/10ps
interface sfr_cause_if;
  logic [7:0] cause;
  logic captured;
  logic sys_reset_req;
  modport producer (output cause, output captured, output sys_reset_req);
  modport consumer (input cause, input captured, input sys_reset_req);
endinterface

// *** src/sfr_reset_cause.sv ***
// Tracks why the system was reset and latches the code after release.
// Assumes poresetn is a power-on reset that hresetn never outlives.
`timescale 1ns/10ps
module sfr_reset_cause (
  input wire logic hclk, // System clock
  input wire logic hresetn, // System reset, async, active low
  input wire logic poresetn, // Power-on reset, async, active low
  input wire logic wdog_reset_req, // Watchdog overflow reset request
  sfr_cause_if.producer cause_bus // Captured cause toward the bank
);

  logic pending_ff;
  logic captured_ff;
  logic captured_d_ff;
  logic [7:0] cause_ff;
  logic req_ff;
  logic clear_pending;

  // Pending survives the system reset it triggers; power-on or the first cycle after capture clears it
  assign clear_pending = captured_ff & ~captured_d_ff;

  always_ff @(posedge hclk or negedge poresetn) begin
    if (!poresetn) begin
      pending_ff <= 1'b0;
    end else if (wdog_reset_req) begin
      pending_ff <= 1'b1;
    end else if (clear_pending) begin
      pending_ff <= 1'b0;
    end
  end

  // Ask the system reset controller for a reset from the request until the system reset arrives
  always_ff @(posedge hclk or negedge poresetn) begin
    if (!poresetn) begin
      req_ff <= 1'b0;
    end else if (!hresetn) begin
      req_ff <= 1'b0;
    end else if (wdog_reset_req) begin
      req_ff <= 1'b1;
    end
  end

  // Capture once, on the first edge after release, then hold
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      captured_ff <= 1'b0;
      captured_d_ff <= 1'b0;
      cause_ff <= sfr_pkg::CAUSE_EXTERNAL_PIN;
    end else begin
      captured_ff <= 1'b1;
      captured_d_ff <= captured_ff;
      if (!captured_ff) begin
        cause_ff <= pending_ff ? sfr_pkg::CAUSE_WATCHDOG
                               : sfr_pkg::CAUSE_EXTERNAL_PIN;
      end
    end
  end

  assign cause_bus.cause = cause_ff;
  assign cause_bus.captured = captured_ff;
  assign cause_bus.sys_reset_req = req_ff;

endmodule

// *** verification/sfr_sva.sv ***
// Checker for the special-function register bank, on its top ports only.
// Assumes hready is tied to hreadyout and a single master.
`timescale 1ns/10ps
module sfr_sva #(
  parameter int ADDR_W = 32
) (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset, active low
  input wire logic poresetn, // Power-on reset
  input wire logic hsel, // Select
  input wire logic [ADDR_W-1:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write
  input wire logic [2:0] hsize, // Size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  input wire logic hreadyout, // Slave ready
  input wire logic hresp, // Response
  input wire logic [31:0] hrdata, // Read data
  input wire logic wdog_reset_req, // Watchdog request
  input wire logic sys_reset_req, // Reset request out
  input wire logic interrupt_protect_enable // Protect mode out
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic taken;
  logic rd;
  assign taken = hsel && hready && htrans == sfr_pkg::HTRANS_NONSEQ && hsize == 3'h2
    && haddr[ADDR_W-1:8] == '0;
  assign rd = taken && !hwrite;

  resp_okay_a: assert property (hresp == sfr_pkg::HRESP_OKAY)
    else $error("hresp not okay");
  read_wait_a: assert property (rd |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  ext_zero_a: assert property (rd && haddr[7:0] == 8'h04 |-> ##2 hrdata == 32'h0)
    else $error("extension word not zero");
  rsvd_zero_a: assert property (rd && haddr[7:0] inside {8'h0c, 8'h10, 8'h14}
    |-> ##2 hrdata == 32'h0)
    else $error("reserved word not zero");
  cause_code_a: assert property (rd && haddr[7:0] == 8'h08
    |-> ##2 (hrdata == 32'h6c || hrdata == 32'h53))
    else $error("reset cause code invalid");
  key_reads_zero_a: assert property (rd && haddr[7:0] == 8'h18
    |-> ##2 hrdata == {26'h0, interrupt_protect_enable, 5'h0})
    else $error("protect word read wrong");
  protect_key_a: assert property ($changed(interrupt_protect_enable)
    |-> $past(taken && hwrite && haddr[7:0] == 8'h18, 2)
    && $past(hwdata[31:16]) == 16'h27a8
    && $past(hwdata[5]) == interrupt_protect_enable)
    else $error("protect bit changed without key");
  wdog_req_a: assert property (wdog_reset_req |=> sys_reset_req)
    else $error("watchdog request not forwarded");
  rdata_idle_a: assert property (hreadyout && $past(hreadyout) |-> hrdata == 32'h0)
    else $error("hrdata not zero outside read");

  cover property (rd && haddr[7:0] == 8'h08);
  cover property ($rose(interrupt_protect_enable));
  cover property ($rose(sys_reset_req));
endmodule

bind sfr_top sfr_sva #(.ADDR_W(ADDR_W)) u_sva (.hclk(hclk), .hresetn(hresetn),
  .poresetn(poresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .wdog_reset_req(wdog_reset_req), .sys_reset_req(sys_reset_req),
  .interrupt_protect_enable(interrupt_protect_enable));

// *** verification/tb.sv ***
// Self-checking bench for the register bank over AHB-Lite.
// Assumes the bank answers reads with one wait state, writes with none.
`timescale 1ns/10ps
module tb;
  logic hclk;
  logic hresetn;
  logic poresetn;
  logic hsel;
  logic hwrite;
  logic hreadyout;
  logic hresp;
  logic wdog_reset_req;
  logic sys_reset_req;
  logic interrupt_protect_enable;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int n_errors = 0;
  int samples_checked = 0;
  // Non-default parameters, family code and nonvolatile data size aside, so every identity field but the nonvolatile data size differs from zero
  localparam logic [31:0] ID_EXP = {1'b1, 3'h3, 8'h12, 4'h8, 4'h0, 4'h9, 3'h2, 5'h1f};

  sfr_top #(.CHIP_VERSION(5'h1f), .PROGRAM_MEMORY_SIZE(sfr_pkg::PSIZE_256K),
    .NONVOLATILE_DATA_SIZE(sfr_pkg::NVDSIZE_NONE), .VOLATILE_DATA_SIZE(sfr_pkg::VDSIZE_8K),
    .FAMILY_CODE(8'h12), .PROGRAM_MEMORY_TYPE(sfr_pkg::PTYPE_FLASH_SERIAL),
    .IDENTITY_EXTENDED(1'b1)) dut (.hclk(hclk), .hresetn(hresetn), .poresetn(poresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .wdog_reset_req(wdog_reset_req), .sys_reset_req(sys_reset_req),
    .interrupt_protect_enable(interrupt_protect_enable));

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Master holds each phase until hready is sampled high; only the watchdog ends a wait
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= sfr_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      @(posedge hclk);
    end
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      @(posedge hclk);
    end
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask

  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
  endtask

  task automatic t_ident();
    rdc("identity", 8'h00, ID_EXP);
    bus(1'b1, 8'h00, 32'h0);
    rdc("identity after write", 8'h00, ID_EXP);
  endtask

  task automatic t_space();
    logic [7:0] offs[6] = '{8'h04, 8'h0c, 8'h10, 8'h14, 8'h1c, 8'h40};
    foreach (offs[i]) begin
      bus(1'b1, offs[i], 32'hffffffff);
      rdc("reserved word", offs[i], 32'h0);
    end
    rdc("cause after writes", 8'h08, 32'h6c);
    rdc("protect after writes", 8'h18, 32'h0);
  endtask

  task automatic t_protect();
    bus(1'b1, 8'h18, 32'h27a90020);
    rdc("protect bad key", 8'h18, 32'h0);
    chk("protect out", 32'h0, {31'h0, interrupt_protect_enable});
    hsize <= 3'h0;
    bus(1'b1, 8'h18, 32'h27a80020);
    hsize <= 3'h2;
    rdc("protect byte write", 8'h18, 32'h0);
    bus(1'b1, 8'h1a, 32'h27a80020);
    rdc("protect misaligned write", 8'h18, 32'h0);
    rdc("cause misaligned read", 8'h09, 32'h0);
    bus(1'b1, 8'h18, 32'h27a80020);
    rdc("protect set", 8'h18, 32'h20);
    chk("protect out", 32'h1, {31'h0, interrupt_protect_enable});
    bus(1'b1, 8'h18, 32'h00000000);
    rdc("protect zero key", 8'h18, 32'h20);
    bus(1'b1, 8'h18, 32'h27a80000);
    rdc("protect clear", 8'h18, 32'h0);
  endtask

  task automatic t_cause();
    bus(1'b1, 8'h18, 32'h27a80020);
    @(posedge hclk);
    wdog_reset_req <= 1'b1;
    @(posedge hclk);
    wdog_reset_req <= 1'b0;
    @(posedge hclk);
    chk("reset request", 32'h1, {31'h0, sys_reset_req});
    do_reset();
    chk("protect after reset", 32'h0, {31'h0, interrupt_protect_enable});
    chk("reset request cleared", 32'h0, {31'h0, sys_reset_req});
    rdc("cause watchdog", 8'h08, 32'h53);
    rdc("cause held", 8'h08, 32'h53);
    do_reset();
    rdc("cause pin", 8'h08, 32'h6c);
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    hresetn = 1'b0;
    poresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    wdog_reset_req = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    poresetn <= 1'b1;
    rdc("cause power up", 8'h08, 32'h6c);
    t_ident();
    t_space();
    t_protect();
    t_cause();
    summarize();
  end

  // The whole sequence needs about 150 cycles
  initial begin
    repeat (3000) @(posedge hclk);
    n_errors++;
    $display("Error watchdog expected done seen timeout");
    summarize();
  end
endmodule
